// >>> link_status_alias_gpio_regs.sv
`timescale 1ns/10ps
module link_status_alias_gpio_regs #(
    parameter int         PORTS       = 2,
    parameter logic [3:0] REVISION_ID = 4'h1   // Arbitrary value
) (
    input  wire logic             mclk,
    input  wire logic             rst_n,
    input  wire logic [7:0]       reg_addr,
    input  wire logic             reg_wr,
    input  wire logic [7:0]       reg_wdata,
    input  wire logic             reg_rd,
    output logic      [7:0]       reg_rdata,
    input  wire logic             second_port_select,
    input  wire logic             crc_reset_ctl,
    input  wire logic             i2c_req,
    input  wire logic [6:0]       i2c_addr,
    output logic                  fwd_valid,
    output logic                  fwd_hit,
    output logic                  fwd_port,
    output logic      [6:0]       fwd_addr,
    input  wire logic [PORTS-1:0] link_detect,
    input  wire logic [PORTS-1:0] crc_err,
    input  wire logic [PORTS-1:0] built_in_self_test_crc_err,
    input  wire logic [PORTS-1:0] built_in_self_test_restart,
    input  wire logic             pclk_detect,
    input  wire logic [PORTS-1:0] remote_pin_val,
    input  wire logic [PORTS-1:0] pin_i,
    output logic      [PORTS-1:0] pin_o,
    output logic      [PORTS-1:0] pin_oe,
    output logic      [PORTS-1:0] pin_in_value
);

    typedef struct packed {
        logic [PORTS-1:0][6:0]  target;
        logic [PORTS-1:0][6:0]  alias_id;
        logic [PORTS-1:0][15:0] crc_count;
        logic [PORTS-1:0]       built_in_self_test_err;
        logic [PORTS-1:0]       des_err;
        logic [PORTS-1:0]       pin_val;
        logic [PORTS-1:0][2:0]  pin_mode;
        logic [PORTS-1:0]       pin_s1;
        logic [PORTS-1:0]       pin_s2;
        logic                   pclk_s1;
        logic                   pclk_s2;
        logic [7:0]             rdata;
        logic                   fwd_valid;
        logic                   fwd_hit;
        logic                   fwd_port;
        logic [6:0]             fwd_addr;
    } regs_t;

    regs_t regs_r;
    regs_t regs_nxt;
    logic  sel;

    // Slave reachable only with both addresses non-zero
    function automatic logic alias_open(input logic [6:0] target, input logic [6:0] alias_id);
        return (target != link_regs_pkg::ADDR_RST) && (alias_id != link_regs_pkg::ADDR_RST);
    endfunction

    // Register read multiplexer for selected port
    function automatic logic [7:0] read_mux(input regs_t r, input logic p,
                                            input logic [7:0] addr, input logic link);
        logic [7:0] d;
        d = 8'h00;
        unique case (addr)
            link_regs_pkg::OFS_SLAVE_TARGET: d = {r.target[p], 1'b0};
            link_regs_pkg::OFS_SLAVE_ALIAS:  d = {r.alias_id[p], 1'b0};
            link_regs_pkg::OFS_CRC_LOW:      d = r.crc_count[p][7:0];
            link_regs_pkg::OFS_CRC_HIGH:     d = r.crc_count[p][15:8];
            link_regs_pkg::OFS_STATUS: begin
                d[link_regs_pkg::STAT_BUILT_IN_SELF_TEST_BIT] = r.built_in_self_test_err[p];
                d[link_regs_pkg::STAT_PCLK_BIT] = r.pclk_s2;
                d[link_regs_pkg::STAT_DES_BIT]  = r.des_err[p];
                d[link_regs_pkg::STAT_LINK_BIT] = link;
            end
            link_regs_pkg::OFS_PIN_CFG: begin
                d[link_regs_pkg::REV_MSB:link_regs_pkg::REV_LSB] = REVISION_ID;
                d[link_regs_pkg::PIN_VAL_BIT] = r.pin_val[p];
                d[link_regs_pkg::PIN_MODE_MSB:link_regs_pkg::PIN_MODE_LSB] = r.pin_mode[p];
            end
            default: d = 8'h00;
        endcase
        return d;
    endfunction

    assign sel = second_port_select;

    // Next state of the whole register bank
    always_comb begin
        regs_nxt = regs_r;
        // Pin and pixel clock synchronisers
        regs_nxt.pin_s1  = pin_i;
        regs_nxt.pin_s2  = regs_r.pin_s1;
        regs_nxt.pclk_s1 = pclk_detect;
        regs_nxt.pclk_s2 = regs_r.pclk_s1;

        // Host writes; read-only addresses fall through
        if (reg_wr) begin
            unique case (reg_addr)
                link_regs_pkg::OFS_SLAVE_TARGET:
                    regs_nxt.target[sel] = reg_wdata[link_regs_pkg::ADDR_MSB:link_regs_pkg::ADDR_LSB];
                link_regs_pkg::OFS_SLAVE_ALIAS:
                    regs_nxt.alias_id[sel] = reg_wdata[link_regs_pkg::ADDR_MSB:link_regs_pkg::ADDR_LSB];
                link_regs_pkg::OFS_PIN_CFG: begin
                    regs_nxt.pin_val[sel]  = reg_wdata[link_regs_pkg::PIN_VAL_BIT];
                    regs_nxt.pin_mode[sel] =
                        reg_wdata[link_regs_pkg::PIN_MODE_MSB:link_regs_pkg::PIN_MODE_LSB];
                end
                default: ;
            endcase
        end

        // Registered read data
        if (reg_rd) begin
            regs_nxt.rdata = read_mux(regs_r, sel, reg_addr, link_detect[sel]);
        end

        // Per-port counters and flags
        for (int p = 0; p < PORTS; p++) begin
            if (crc_reset_ctl) begin
                regs_nxt.crc_count[p] = link_regs_pkg::CRC_RST;
            end else if (crc_err[p] && regs_r.crc_count[p] != link_regs_pkg::CRC_MAX) begin
                regs_nxt.crc_count[p] = regs_r.crc_count[p] + 16'h0001;
            end
            regs_nxt.built_in_self_test_err[p] = built_in_self_test_crc_err[p] |
                (regs_r.built_in_self_test_err[p] & link_detect[p] & ~built_in_self_test_restart[p] & ~crc_reset_ctl);
            regs_nxt.des_err[p] = crc_err[p] |
                (regs_r.des_err[p] & link_detect[p] & ~crc_reset_ctl);
        end

        regs_nxt.fwd_valid = i2c_req;
        if (i2c_req) begin
            regs_nxt.fwd_hit  = 1'b0;
            regs_nxt.fwd_port = 1'b0;
            regs_nxt.fwd_addr = link_regs_pkg::ADDR_RST;
            for (int p = PORTS - 1; p >= 0; p--) begin
                if (alias_open(regs_r.target[p], regs_r.alias_id[p]) &&
                    regs_r.alias_id[p] == i2c_addr) begin
                    regs_nxt.fwd_hit  = 1'b1;
                    regs_nxt.fwd_port = p[0];
                    regs_nxt.fwd_addr = regs_r.target[p];
                end
            end
        end
    end

    // State register, synchronous reset
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            regs_r <= '0;
        end else begin
            regs_r <= regs_nxt;
        end
    end

    // Pin drivers per port
    for (genvar g = 0; g < PORTS; g++) begin : g_pin
        pin_zero_drive u_drive (
            .mclk       (mclk),
            .rst_n      (rst_n),
            .mode       (regs_r.pin_mode[g]),
            .out_val    (regs_r.pin_val[g]),
            .remote_val (remote_pin_val[g]),
            .link_up    (link_detect[g]),
            .pin_o      (pin_o[g]),
            .pin_oe     (pin_oe[g])
        );
    end

    // Outputs from state
    assign reg_rdata    = regs_r.rdata;
    assign fwd_valid    = regs_r.fwd_valid;
    assign fwd_hit      = regs_r.fwd_hit;
    assign fwd_port     = regs_r.fwd_port;
    assign fwd_addr     = regs_r.fwd_addr;
    assign pin_in_value = regs_r.pin_s2;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    AST_TARGET_PORT_SEL: assert property (
        reg_wr && reg_addr == link_regs_pkg::OFS_SLAVE_TARGET && second_port_select
        |=> regs_r.target[1] == $past(reg_wdata[7:1]) && $stable(regs_r.target[0]))
        else $error("Target write not steered to secondary port");
    AST_ALIAS_READBACK: assert property (
        reg_wr && reg_addr == link_regs_pkg::OFS_SLAVE_ALIAS && !second_port_select
        ##1 reg_rd && reg_addr == link_regs_pkg::OFS_SLAVE_ALIAS && !second_port_select
        |=> reg_rdata == {$past(reg_wdata[7:1], 2), 1'b0})
        else $error("Alias readback mismatch");
    AST_REMAP: assert property (
        i2c_req && regs_r.alias_id[0] == i2c_addr && alias_open(regs_r.target[0], regs_r.alias_id[0])
        |=> fwd_valid && fwd_hit && !fwd_port && fwd_addr == $past(regs_r.target[0]))
        else $error("Alias hit not remapped to target");
    AST_BLOCK_ZERO: assert property (
        i2c_req && regs_r.target[0] == 7'h00 && regs_r.target[1] == 7'h00 |=> !fwd_hit)
        else $error("Access passed with zero target");
    AST_CRC_COUNT: assert property (
        !crc_reset_ctl && crc_err[0] && regs_r.crc_count[0] != 16'hffff
        |=> regs_r.crc_count[0] == 16'($past(regs_r.crc_count[0]) + 16'h0001))
        else $error("CRC counter did not increment");
    AST_CRC_CLEAR: assert property (
        crc_reset_ctl |=> regs_r.crc_count[0] == 16'h0000 && regs_r.crc_count[1] == 16'h0000)
        else $error("CRC counter not cleared");
    AST_BUILT_IN_SELF_TEST_FLAG: assert property (
        !built_in_self_test_crc_err[0] && (!link_detect[0] || built_in_self_test_restart[0]) |=> !regs_r.built_in_self_test_err[0])
        else $error("Self-test flag not cleared");
    AST_DES_FLAG: assert property (
        crc_err[1] |=> regs_r.des_err[1] ##1 (!crc_reset_ctl && link_detect[1]) [*1]
        |=> regs_r.des_err[1])
        else $error("Normal CRC flag not sticky");
    AST_STATUS_READ: assert property (
        reg_rd && reg_addr == link_regs_pkg::OFS_STATUS
        |=> reg_rdata[7:4] == 4'h0 && reg_rdata[0] == $past(link_detect[second_port_select])
            && reg_rdata[2] == $past(regs_r.pclk_s2))
        else $error("Status read mismatch");
    AST_REVISION: assert property (
        reg_rd && reg_addr == link_regs_pkg::OFS_PIN_CFG |=> reg_rdata[7:4] == REVISION_ID)
        else $error("Revision nibble wrong");
    AST_RO_WRITE: assert property (
        reg_wr && reg_addr == link_regs_pkg::OFS_CRC_LOW && !crc_err[0] && !crc_reset_ctl
        |=> $stable(regs_r.crc_count[0]))
        else $error("Write changed read-only counter");

    COV_REMAP_HIT: cover property (i2c_req ##1 fwd_hit);
    COV_CRC_CLEAR: cover property (crc_err[0] ##1 crc_reset_ctl);
    COV_PORT1_READ: cover property (reg_rd && second_port_select);

endmodule // link_status_alias_gpio_regs

// >>> link_regs_pkg.sv
package link_regs_pkg;

    // Register offsets on the serial control bus
    localparam logic [7:0] OFS_SLAVE_TARGET = 8'h07;
    localparam logic [7:0] OFS_SLAVE_ALIAS  = 8'h08;
    localparam logic [7:0] OFS_CRC_LOW      = 8'h0a;
    localparam logic [7:0] OFS_CRC_HIGH     = 8'h0b;
    localparam logic [7:0] OFS_STATUS       = 8'h0c;
    localparam logic [7:0] OFS_PIN_CFG      = 8'h0d;

    // Field positions
    localparam int ADDR_MSB      = 7;
    localparam int ADDR_LSB      = 1;
    localparam int STAT_BUILT_IN_SELF_TEST_BIT = 3;
    localparam int STAT_PCLK_BIT = 2;
    localparam int STAT_DES_BIT  = 1;
    localparam int STAT_LINK_BIT = 0;
    localparam int REV_MSB       = 7;
    localparam int REV_LSB       = 4;
    localparam int PIN_VAL_BIT   = 3;
    localparam int PIN_MODE_MSB  = 2;
    localparam int PIN_MODE_LSB  = 0;

    // Values after reset, and CRC counter ceiling
    localparam logic [6:0]  ADDR_RST    = 7'h00;
    localparam logic [15:0] CRC_RST     = 16'h0000;
    localparam logic [15:0] CRC_MAX     = 16'hffff;
    localparam logic [2:0]  MODE_RST    = 3'h0;
    localparam logic        PIN_VAL_RST = 1'b0;
    localparam logic [7:0]  RDATA_RST   = 8'h00;

    // Pin mode codes
    localparam logic [2:0] MODE_LOCAL_OUT      = 3'h1;
    localparam logic [2:0] MODE_LOCAL_IN       = 3'h3;
    localparam logic [2:0] MODE_REMOTE_HOLD    = 3'h5;
    localparam logic [2:0] MODE_REMOTE_DEFAULT = 3'h7;

    typedef enum logic [2:0] {
        ACT_HIZ,
        ACT_LOCAL_OUT,
        ACT_LOCAL_IN,
        ACT_REMOTE_HOLD,
        ACT_REMOTE_DEFAULT
    } pin_act_t;

    // Mode field to pin action
    function automatic pin_act_t decode_mode(input logic [2:0] mode);
        pin_act_t act;
        act = ACT_HIZ;
        if (mode[0]) begin
            unique case (mode[2:1])
                2'h0: act = ACT_LOCAL_OUT;
                2'h1: act = ACT_LOCAL_IN;
                2'h2: act = ACT_REMOTE_HOLD;
                2'h3: act = ACT_REMOTE_DEFAULT;
            endcase
        end
        return act;
    endfunction

endpackage

// >>> pin_zero_drive.sv
`timescale 1ns/10ps
module pin_zero_drive (
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic [2:0] mode,
    input  wire logic       out_val,
    input  wire logic       remote_val,
    input  wire logic       link_up,
    output logic            pin_o,
    output logic            pin_oe
);

    typedef struct packed {
        logic pin_o;
        logic pin_oe;
        logic hold_val;
    } drv_t;

    drv_t                     drv_r;
    drv_t                     drv_nxt;
    link_regs_pkg::pin_act_t  act;

    // Pin action from mode, remote value tracking
    always_comb begin
        drv_nxt = drv_r;
        act = link_regs_pkg::decode_mode(mode);
        if (link_up) begin
            drv_nxt.hold_val = remote_val;
        end
        unique case (act)
            link_regs_pkg::ACT_HIZ, link_regs_pkg::ACT_LOCAL_IN: begin
                drv_nxt.pin_oe = 1'b0;
                drv_nxt.pin_o  = 1'b0;
            end
            link_regs_pkg::ACT_LOCAL_OUT: begin
                drv_nxt.pin_oe = 1'b1;
                drv_nxt.pin_o  = out_val;
            end
            link_regs_pkg::ACT_REMOTE_HOLD: begin
                drv_nxt.pin_oe = 1'b1;
                drv_nxt.pin_o  = link_up ? remote_val : drv_r.hold_val;
            end
            link_regs_pkg::ACT_REMOTE_DEFAULT: begin
                drv_nxt.pin_oe = 1'b1;
                drv_nxt.pin_o  = link_up ? remote_val : out_val;
            end
        endcase
    end

    // State register
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            drv_r <= '0;
        end else begin
            drv_r <= drv_nxt;
        end
    end

    assign pin_o  = drv_r.pin_o;
    assign pin_oe = drv_r.pin_oe;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    AST_PIN_LOCAL_OUT: assert property (
        mode == link_regs_pkg::MODE_LOCAL_OUT |=> pin_oe && pin_o == $past(out_val))
        else $error("Local output mode not driving value bit");
    AST_PIN_HIZ: assert property (
        !mode[0] || mode == link_regs_pkg::MODE_LOCAL_IN |=> !pin_oe)
        else $error("Pin driven in high impedance or input mode");
    AST_PIN_HOLD: assert property (
        mode == link_regs_pkg::MODE_REMOTE_HOLD && link_up
        ##1 mode == link_regs_pkg::MODE_REMOTE_HOLD && !link_up
        |=> pin_oe && pin_o == $past(remote_val, 2))
        else $error("Remote hold lost last value");
    AST_PIN_DEFAULT: assert property (
        mode == link_regs_pkg::MODE_REMOTE_DEFAULT && !link_up |=> pin_o == $past(out_val))
        else $error("Remote default not using value bit");
    COV_PIN_HOLD: cover property (
        mode == link_regs_pkg::MODE_REMOTE_HOLD && link_up ##1 !link_up);

endmodule // pin_zero_drive

// >>> reg_host.sv
`timescale 1ns/10ps
// Local host on the register strobe bus
module reg_host (
    input  wire logic       mclk,
    output logic      [7:0] reg_addr,
    output logic            reg_wr,
    output logic      [7:0] reg_wdata,
    output logic            reg_rd,
    input  wire logic [7:0] reg_rdata,
    output logic            second_port_select,
    output logic            crc_reset_ctl
);
    // Quiet bus at time zero
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        reg_rd = 1'b0;
        second_port_select = 1'b0;
        crc_reset_ctl = 1'b0;
    end

    // One write; released lines show the inverse
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask

    // One read; data valid after the taking edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        #1;
        d = reg_rdata;
    endtask

    // Port steering level
    task automatic port(input logic s);
        @(posedge mclk);
        second_port_select <= s;
    endtask

    task automatic crc_clear();
        @(posedge mclk);
        crc_reset_ctl <= 1'b1;
        repeat (2) @(posedge mclk);
        crc_reset_ctl <= 1'b0;
    endtask
endmodule // reg_host

// >>> link_status_alias_gpio_regs_tb.sv
`timescale 1ns/10ps
// Self-checking bench for the link register slice
module link_status_alias_gpio_regs_tb;
    localparam logic [3:0] REV = 4'h5; // Arbitrary value
    logic       mclk;
    logic       rst_n;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic       reg_wr, reg_rd, sps, crc_rst;
    logic       i2c_req;
    logic [6:0] i2c_addr;
    logic       fwd_valid, fwd_hit, fwd_port;
    logic [6:0] fwd_addr;
    logic [1:0] link_detect, crc_err, built_in_self_test_crc_err;
    logic [1:0] built_in_self_test_restart, remote_pin_val, pin_i;
    logic       pclk_detect;
    logic [1:0] pin_o, pin_oe, pin_in_value;
    int         fail_count = 0, checked = 0, cycles = 0;

    link_status_alias_gpio_regs #(.PORTS(2), .REVISION_ID(REV)) uut (
        .mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .second_port_select(sps), .crc_reset_ctl(crc_rst), .i2c_req(i2c_req),
        .i2c_addr(i2c_addr), .fwd_valid(fwd_valid), .fwd_hit(fwd_hit),
        .fwd_port(fwd_port), .fwd_addr(fwd_addr), .link_detect(link_detect),
        .crc_err(crc_err), .built_in_self_test_crc_err(built_in_self_test_crc_err), .built_in_self_test_restart(built_in_self_test_restart),
        .pclk_detect(pclk_detect), .remote_pin_val(remote_pin_val), .pin_i(pin_i),
        .pin_o(pin_o), .pin_oe(pin_oe), .pin_in_value(pin_in_value));

    reg_host host (
        .mclk(mclk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .second_port_select(sps),
        .crc_reset_ctl(crc_rst));

    // 10 MHz clock and hang guard
    initial mclk = 1'b0;
    always #50 mclk = ~mclk;
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 4000) begin
            fail_count++;
            test_done();
        end
    end

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        host.rd(a, d);
        chk(what, {8'h00, d}, {8'h00, e});
    endtask

    // Event pulse held high for n edges: 0 crc, 1 self-test error, 2 restart
    task automatic ev(input int k, input logic [1:0] m, input int n);
        @(posedge mclk);
        case (k)
            0: crc_err <= m;
            1: built_in_self_test_crc_err <= m;
            default: built_in_self_test_restart <= m;
        endcase
        repeat (n) @(posedge mclk);
        crc_err <= 2'h0;
        built_in_self_test_crc_err <= 2'h0;
        built_in_self_test_restart <= 2'h0;
    endtask

    task automatic remap(input logic [6:0] a, input logic hit, input logic p,
                         input logic [6:0] ta);
        @(posedge mclk);
        i2c_req <= 1'b1;
        i2c_addr <= a;
        @(posedge mclk);
        i2c_req <= 1'b0;
        i2c_addr <= ~a;
        #1;
        chk("fwd_valid", 16'(fwd_valid), 16'h1);
        chk("fwd_hit", 16'(fwd_hit), 16'(hit));
        chk("fwd_addr", 16'(fwd_addr), 16'(ta));
        if (hit) chk("fwd_port", 16'(fwd_port), 16'(p));
    endtask

    task automatic cfg(input logic [7:0] c);
        host.wr(8'h0d, c);
        repeat (3) @(posedge mclk);
        #1;
    endtask

    task automatic t_reset();
        rchk("target", 8'h07, 8'h00);
        rchk("alias", 8'h08, 8'h00);
        rchk("pin cfg", 8'h0d, {REV, 4'h0});
        host.wr(8'h0a, 8'hff);
        host.wr(8'h0c, 8'hff);
        host.wr(8'h20, 8'hff);
        rchk("crc low", 8'h0a, 8'h00);
        rchk("crc high", 8'h0b, 8'h00);
        rchk("status", 8'h0c, 8'h00);
        rchk("unmapped", 8'h20, 8'h00);
        $display("test reset done");
    endtask

    task automatic t_remap();
        host.wr(8'h07, 8'h55);
        host.wr(8'h08, 8'h67);
        rchk("target", 8'h07, 8'h54);
        rchk("alias", 8'h08, 8'h66);
        remap(7'h33, 1'b1, 1'b0, 7'h2a);
        remap(7'h34, 1'b0, 1'b0, 7'h00);
        host.port(1'b1);
        host.wr(8'h07, 8'h20);
        host.wr(8'h08, 8'h40);
        rchk("target p1", 8'h07, 8'h20);
        host.port(1'b0);
        rchk("target p0", 8'h07, 8'h54);
        remap(7'h20, 1'b1, 1'b1, 7'h10);
        host.wr(8'h07, 8'h00);
        remap(7'h33, 1'b0, 1'b0, 7'h00);
        host.port(1'b1);
        host.wr(8'h08, 8'h00);
        remap(7'h20, 1'b0, 1'b0, 7'h00);
        host.port(1'b0);
        $display("test remap done");
    endtask

    task automatic t_crc();
        link_detect <= 2'h3;
        ev(0, 2'h1, 3);
        ev(0, 2'h2, 1);
        rchk("crc low", 8'h0a, 8'h03);
        rchk("status", 8'h0c, 8'h03);
        host.port(1'b1);
        rchk("crc low p1", 8'h0a, 8'h01);
        host.port(1'b0);
        host.wr(8'h0a, 8'hff);
        ev(0, 2'h1, 256);
        rchk("crc high", 8'h0b, 8'h01);
        rchk("crc low", 8'h0a, 8'h03);
        host.crc_clear();
        rchk("crc low", 8'h0a, 8'h00);
        rchk("crc high", 8'h0b, 8'h00);
        rchk("status", 8'h0c, 8'h01);
        ev(0, 2'h1, 1);
        link_detect <= 2'h2;
        rchk("status", 8'h0c, 8'h00);
        link_detect <= 2'h3;
        $display("test crc done");
    endtask

    task automatic t_built_in_self_test();
        ev(1, 2'h1, 1);
        rchk("status", 8'h0c, 8'h09);
        ev(2, 2'h1, 1);
        rchk("status", 8'h0c, 8'h01);
        ev(1, 2'h1, 1);
        link_detect <= 2'h2;
        rchk("status", 8'h0c, 8'h00);
        link_detect <= 2'h3;
        ev(1, 2'h3, 1);
        host.crc_clear();
        ev(1, 2'h2, 1);
        rchk("status", 8'h0c, 8'h01);
        host.port(1'b1);
        rchk("status p1", 8'h0c, 8'h09);
        host.port(1'b0);
        pclk_detect <= 1'b1;
        repeat (3) @(posedge mclk);
        rchk("status", 8'h0c, 8'h05);
        $display("test built_in_self_test done");
    endtask

    task automatic t_pin();
        for (int m = 0; m < 8; m += 2) begin
            cfg(8'h08 | 8'(m));
            chk("oe hiz", 16'(pin_oe[0]), 16'h0);
        end
        cfg(8'h09);
        chk("oe out", 16'(pin_oe[0]), 16'h1);
        chk("pin out", 16'(pin_o[0]), 16'h1);
        rchk("pin cfg", 8'h0d, {REV, 4'h9});
        cfg(8'h01);
        chk("pin low", 16'(pin_o[0]), 16'h0);
        cfg(8'h03);
        pin_i <= 2'h1;
        repeat (4) @(posedge mclk);
        #1;
        chk("oe in", 16'(pin_oe[0]), 16'h0);
        chk("pin in", 16'(pin_in_value[0]), 16'h1);
        remote_pin_val <= 2'h1;
        cfg(8'h05);
        chk("hold", 16'(pin_o[0]), 16'h1);
        link_detect <= 2'h2;
        remote_pin_val <= 2'h0;
        cfg(8'h05);
        chk("hold loss", 16'(pin_o[0]), 16'h1);
        link_detect <= 2'h3;
        remote_pin_val <= 2'h1;
        cfg(8'h07);
        chk("default", 16'(pin_o[0]), 16'h1);
        link_detect <= 2'h2;
        cfg(8'h07);
        chk("default loss", 16'(pin_o[0]), 16'h0);
        host.port(1'b1);
        cfg(8'h09);
        chk("oe p1", 16'(pin_oe[1]), 16'h1);
        host.port(1'b0);
        $display("test pin done");
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        // Idle levels on every driven input
        rst_n <= 1'b0;
        i2c_req <= 1'b0;
        i2c_addr <= 7'h00;
        link_detect <= 2'h0;
        crc_err <= 2'h0;
        built_in_self_test_crc_err <= 2'h0;
        built_in_self_test_restart <= 2'h0;
        remote_pin_val <= 2'h0;
        pin_i <= 2'h0;
        pclk_detect <= 1'b0;
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        t_reset();
        t_remap();
        t_crc();
        t_built_in_self_test();
        t_pin();
        test_done();
    end
endmodule // link_status_alias_gpio_regs_tb
